/* hw/fpm_pkg.sv */
// Package for the front panel parameter menu
package fpm_pkg;
	localparam int CLK_HZ            = 125_000_000;
	localparam int IDLE_TIME_S       = 30;
	localparam longint IDLE_CYCLES   = longint'(IDLE_TIME_S) * CLK_HZ;
	localparam int DEBOUNCE_TIME_MS  = 20;
	localparam int DEBOUNCE_CYCLES   = DEBOUNCE_TIME_MS * (CLK_HZ / 1000);
	localparam int REPEAT_DELAY_MS   = 500;
	localparam int REPEAT_DELAY_CYC  = REPEAT_DELAY_MS * (CLK_HZ / 1000);
	localparam int REPEAT_RATE_MS    = 100;
	localparam int REPEAT_RATE_CYC   = REPEAT_RATE_MS * (CLK_HZ / 1000);
	localparam int FLASH_TIME_MS     = 250;
	localparam int FLASH_CYCLES      = FLASH_TIME_MS * (CLK_HZ / 1000);
	// Special page numbers
	localparam logic [7:0] PAGE_OPERATOR = 8'h00;
	localparam logic [7:0] PAGE_DEFAULTS = 8'h63;
	localparam logic [7:0] PAGE_LOCK     = 8'h7B;
	localparam logic [7:0] PAGE_MAX      = 8'hFF;
	// Lower readout tag codes
	localparam logic [15:0] TAG_PAGE     = 16'hFA6E;
	localparam logic [15:0] TAG_MAIN     = 16'h0000;
	// Factory lock state
	localparam logic LOCK_RESET          = 1'b0;
	typedef enum logic [2:0] {
		FPM_MAIN    = 3'b000,
		FPM_PAGESEL = 3'b001,
		FPM_LOOKUP  = 3'b010,
		FPM_SKIP    = 3'b011,
		FPM_SHOW    = 3'b100,
		FPM_COMMIT  = 3'b101,
		FPM_DEFAULT = 3'b110
	} fpm_state_type;
	// One cleaned key event per key
	typedef struct packed {
		logic page;
		logic up;
		logic down;
		logic enter;
	} fpm_keys_type;
	// Attributes of one table entry
	typedef struct packed {
		logic [7:0]  page;
		logic [15:0] tag;
		logic signed [15:0] min_val;
		logic signed [15:0] max_val;
		logic signed [15:0] def_val;
		logic        last;
	} fpm_param_type;
endpackage

/* hw/fpm_menu.sv */
// Front panel parameter menu state machine
`timescale 1ns/10ps
// Summary of operation
// - Show tag low, value high, fixed order
// - Page key shows PAGE and 0
// - Page number steps one, faster held
// - Enter valid page shows first parameter
// - Invalid page returns to main display
// - Enter advances, last wraps to first
// - Up/down step value, held repeats faster
// - Flash at limit, ignore further step
// - Enter commits value, shows next parameter
// - Uncommitted value dropped; power up main
// - Thirty seconds idle returns to main
// - Skip parameters whose condition fails
// - Lock allows viewing, blocks adjustment
// - Lock cleared in factory condition
// - Page 123 unlocked enables lock
// - Page 123 twice per power unlocks
// - Set-up enable allows setpoint under lock
// - Manual enable allows valve adjust locked
// - Page zero gated by adjust enable
// - Locked page 99 treated as invalid
// - Page 99 unlocked restores all defaults
// - Defaults use resolution 1, Celsius
module fpm_menu
	import fpm_pkg::*;
#(
	parameter int NPAR        = 8,
	parameter int IDX_W       = 3,
	parameter longint IDLE_CYC = IDLE_CYCLES,
	parameter int DEB_CYC     = DEBOUNCE_CYCLES,
	parameter int RPT_DLY     = REPEAT_DELAY_CYC,
	parameter int RPT_RATE    = REPEAT_RATE_CYC
) (
	// Clock and power-on reset
	input  wire logic               clk,
	input  wire logic               rst,
	// Raw front panel keys, high while pressed
	input  wire logic               key_page_in,
	input  wire logic               key_up_in,
	input  wire logic               key_down_in,
	input  wire logic               key_enter_in,
	// Parameter table, one entry per index
	input  wire fpm_param_type      par_table [NPAR],
	input  wire logic [NPAR-1:0]    par_enabled,
	input  wire logic [NPAR-1:0]    par_setpoint,
	input  wire logic [NPAR-1:0]    par_valve,
	// Supervisory enables
	input  wire logic               sup_setup_en,
	input  wire logic               sup_manual_en,
	input  wire logic               sup_adjust_en,
	// Non-volatile store interface
	input  wire logic signed [15:0] nv_rd_data,
	output logic [IDX_W-1:0]        nv_addr,
	output logic                    nv_wr,
	output logic signed [15:0]      nv_wr_data,
	output logic                    restart_req,
	// Readouts and status
	output logic [15:0]             upper_value,
	output logic [15:0]             lower_tag,
	output logic                    upper_flash,
	output logic                    program_mode,
	output logic                    lock_on
);
	localparam int DB_W = $clog2(DEB_CYC + 1);
	localparam int RP_W = $clog2(RPT_DLY + 1);
	localparam int ID_W = $clog2(IDLE_CYC + 1);

	logic [3:0]          raw_s1;
	logic [3:0]          raw_s2;
	logic [3:0]          clean;
	logic [3:0]          clean_d;
	logic [DB_W-1:0]     db_cnt [4];
	logic [RP_W-1:0]     rpt_cnt;
	fpm_keys_type        ev;
	logic                rpt_up;
	logic                rpt_down;
	fpm_state_type       state;
	logic [7:0]          page_num;
	logic [IDX_W-1:0]    idx;
	logic [IDX_W-1:0]    scan_start;
	logic signed [15:0]  edit_val;
	logic                edited;
	logic                unlock_armed;
	logic [ID_W-1:0]     idle_cnt;
	logic                idle_expire;
	logic                may_adjust;
	logic                at_max;
	logic                at_min;

	// True when index i is the page's entry of interest and enabled
	function automatic logic visible(input int i, input logic [7:0] pg);
		visible = (par_table[i].page == pg) && par_enabled[i];
	endfunction

	// Next index with wrap
	function automatic logic [IDX_W-1:0] wrap_inc(input logic [IDX_W-1:0] v);
		if (int'(v) == NPAR - 1) begin
			wrap_inc = '0;
		end else begin
			wrap_inc = v + 1'b1;
		end
	endfunction

	// Two-stage synchroniser for the key pins
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			raw_s1 <= 4'h0;
			raw_s2 <= 4'h0;
		end else begin
			raw_s1 <= {key_page_in, key_up_in, key_down_in, key_enter_in};
			raw_s2 <= raw_s1;
		end
	end

	// Debounce: a key state changes only after it is stable long enough
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			clean <= 4'h0;
			for (int k = 0; k < 4; k++) begin
				db_cnt[k] <= '0;
			end
		end else begin
			for (int k = 0; k < 4; k++) begin
				if (raw_s2[k] == clean[k]) begin
					db_cnt[k] <= '0;
				end else if (int'(db_cnt[k]) >= DEB_CYC - 1) begin
					clean[k]  <= raw_s2[k];
					db_cnt[k] <= '0;
				end else begin
					db_cnt[k] <= db_cnt[k] + 1'b1;
				end
			end
		end
	end

	// Edge history of the clean keys
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			clean_d <= 4'h0;
		end else begin
			clean_d <= clean;
		end
	end

	// Auto-repeat for held up or down key
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rpt_cnt <= '0;
		end else if (!(clean[2] ^ clean[1])) begin
			rpt_cnt <= '0;
		end else if (int'(rpt_cnt) >= RPT_DLY - 1) begin
			rpt_cnt <= RP_W'(RPT_DLY - RPT_RATE);
		end else begin
			rpt_cnt <= rpt_cnt + 1'b1;
		end
	end

	assign rpt_up   = clean[2] && !clean[1] && int'(rpt_cnt) >= RPT_DLY - 1;
	assign rpt_down = clean[1] && !clean[2] && int'(rpt_cnt) >= RPT_DLY - 1;

	// Events: page and enter on release, up/down on press or repeat
	always_comb begin
		ev.page  = clean_d[3] && !clean[3];
		ev.enter = clean_d[0] && !clean[0];
		ev.up    = (clean[2] && !clean_d[2]) || rpt_up;
		ev.down  = (clean[1] && !clean_d[1]) || rpt_down;
	end

	// Adjustment permission and limit checks for the shown entry
	always_comb begin
		if (par_table[idx].page == PAGE_OPERATOR) begin
			may_adjust = sup_adjust_en;
		end else if (!lock_on) begin
			may_adjust = 1'b1;
		end else if (par_setpoint[idx]) begin
			may_adjust = sup_setup_en;
		end else if (par_valve[idx]) begin
			may_adjust = sup_manual_en;
		end else begin
			may_adjust = 1'b0;
		end
		at_max = edit_val >= par_table[idx].max_val;
		at_min = edit_val <= par_table[idx].min_val;
	end

	// Idle timer: reloaded by any key, held clear in main display
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			idle_cnt <= '0;
		end else if (state == FPM_MAIN || (ev != '0)) begin
			idle_cnt <= '0;
		end else if (!idle_expire) begin
			idle_cnt <= idle_cnt + 1'b1;
		end
	end

	assign idle_expire = longint'(idle_cnt) >= IDLE_CYC;

	// Lock bit and pending unlock entry; both lost at power-on
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lock_on      <= LOCK_RESET;
			unlock_armed <= 1'b0;
		end else if (state == FPM_PAGESEL && ev.enter
				&& page_num == PAGE_LOCK) begin
			if (!lock_on) begin
				lock_on <= 1'b1;
			end else if (unlock_armed) begin
				lock_on      <= 1'b0;
				unlock_armed <= 1'b0;
			end else begin
				unlock_armed <= 1'b1;
			end
		end
	end

	// Menu sequencer
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state       <= FPM_MAIN;
			page_num    <= 8'h00;
			idx         <= '0;
			scan_start  <= '0;
			edit_val    <= 16'sh0000;
			edited      <= 1'b0;
			nv_wr       <= 1'b0;
			nv_wr_data  <= 16'sh0000;
			restart_req <= 1'b0;
		end else begin
			nv_wr       <= 1'b0;
			restart_req <= 1'b0;
			if (idle_expire && state != FPM_MAIN) begin
				state  <= FPM_MAIN;
				edited <= 1'b0;
			end else begin
				case (state)
				FPM_MAIN: begin
					if (ev.page) begin
						page_num <= PAGE_OPERATOR;
						state    <= FPM_PAGESEL;
					end
				end
				FPM_PAGESEL: begin
					if (ev.page) begin
						state <= FPM_MAIN;
					end else if (ev.up && page_num != PAGE_MAX) begin
						page_num <= page_num + 8'h01;
					end else if (ev.down && page_num != 8'h00) begin
						page_num <= page_num - 8'h01;
					end else if (ev.enter) begin
						if (page_num == PAGE_LOCK) begin
							state <= FPM_MAIN;
						end else if (page_num == PAGE_DEFAULTS
								&& !lock_on) begin
							idx   <= '0;
							state <= FPM_DEFAULT;
						end else begin
							idx        <= '0;
							scan_start <= '0;
							state      <= FPM_LOOKUP;
						end
					end
				end
				FPM_LOOKUP: begin
					// Search the table in order for the first shown entry
					if (visible(int'(idx), page_num)) begin
						edit_val <= nv_rd_data;
						edited   <= 1'b0;
						state    <= FPM_SHOW;
					end else if (int'(idx) == NPAR - 1) begin
						state <= FPM_MAIN;
					end else begin
						idx <= idx + 1'b1;
					end
				end
				FPM_SKIP: begin
					// Walk forward to the next shown entry, wrapping
					if (visible(int'(idx), page_num)) begin
						edit_val <= nv_rd_data;
						edited   <= 1'b0;
						state    <= FPM_SHOW;
					end else begin
						idx <= wrap_inc(idx);
					end
				end
				FPM_SHOW: begin
					if (ev.page) begin
						edited <= 1'b0;
						state  <= FPM_MAIN;
					end else if (ev.enter) begin
						if (edited) begin
							nv_wr      <= 1'b1;
							nv_wr_data <= edit_val;
						end
						state <= FPM_COMMIT;
					end else if (ev.up && may_adjust && !at_max) begin
						edit_val <= edit_val + 16'sh0001;
						edited   <= 1'b1;
					end else if (ev.down && may_adjust && !at_min) begin
						edit_val <= edit_val - 16'sh0001;
						edited   <= 1'b1;
					end
				end
				FPM_COMMIT: begin
					idx   <= wrap_inc(idx);
					state <= FPM_SKIP;
				end
				FPM_DEFAULT: begin
					// Write each default; table defaults are at res 1, C.
					// Step only after the write, so it lands at this index
					if (!nv_wr) begin
						nv_wr      <= 1'b1;
						nv_wr_data <= par_table[idx].def_val;
					end else if (int'(idx) == NPAR - 1) begin
						restart_req <= 1'b1;
						state       <= FPM_MAIN;
					end else begin
						idx <= idx + 1'b1;
					end
				end
				default: begin
					state <= FPM_MAIN;
				end
				endcase
			end
		end
	end

	// Store address is the index flip-flop itself, so a lookup reads
	// the very entry that it tests in the same cycle
	assign nv_addr = idx;

	// Readouts
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			upper_value  <= 16'h0000;
			lower_tag    <= TAG_MAIN;
			upper_flash  <= 1'b0;
			program_mode <= 1'b0;
		end else begin
			program_mode <= state != FPM_MAIN;
			case (state)
			FPM_PAGESEL: begin
				upper_value <= {8'h00, page_num};
				lower_tag   <= TAG_PAGE;
				upper_flash <= 1'b0;
			end
			FPM_SHOW: begin
				upper_value <= edit_val;
				lower_tag   <= par_table[idx].tag;
				upper_flash <= at_max || at_min;
			end
			default: begin
				upper_value <= upper_value;
				lower_tag   <= (state == FPM_MAIN) ? TAG_MAIN : lower_tag;
				upper_flash <= 1'b0;
			end
			endcase
		end
	end
endmodule

/* verification/fpm_menu_assertions.sv */
// Port checker for the parameter menu
`timescale 1ns/10ps
module fpm_menu_checker
	import fpm_pkg::*;
#(
	parameter longint IDLE_CYC = IDLE_CYCLES
) (
	// Clock, reset and raw keys
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        key_page_in,
	input wire logic        key_up_in,
	input wire logic        key_down_in,
	input wire logic        key_enter_in,
	// Supervisory enables
	input wire logic        sup_setup_en,
	input wire logic        sup_manual_en,
	input wire logic        sup_adjust_en,
	// Watched outputs
	input wire logic        restart_req,
	input wire logic [15:0] upper_value,
	input wire logic [15:0] lower_tag,
	input wire logic        upper_flash,
	input wire logic        program_mode,
	input wire logic        lock_on
);
	logic   any_key;
	longint idle;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Any raw key held down
	assign any_key = key_page_in | key_up_in | key_down_in | key_enter_in;
	// Cycles spent in program mode without a key
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			idle <= 0;
		end else if (!program_mode || any_key) begin
			idle <= 0;
		end else begin
			idle <= idle + 1;
		end
	end
	page_entry_a: assert property ($rose(program_mode) |-> ##[1:2]
		(lower_tag == TAG_PAGE && upper_value == 16'h0000))
		else $error("page entry readout wrong");
	page_step_a: assert property ((lower_tag == TAG_PAGE
		&& $past(lower_tag) == TAG_PAGE && $changed(upper_value))
		|-> (upper_value == $past(upper_value) + 16'h0001
		|| upper_value == $past(upper_value) - 16'h0001
		|| (upper_value ^ $past(upper_value)) == 16'h00FF))
		else $error("page number step not one");
	restart_pulse_a: assert property (restart_req |=> !restart_req)
		else $error("restart request too long");
	restart_lock_a: assert property (restart_req |-> !lock_on)
		else $error("defaults restored under lock");
	lock_exit_a: assert property ($changed(lock_on)
		|-> ##[0:2] !program_mode)
		else $error("lock change outside main");
	lock_hold_a: assert property ((lock_on && program_mode
		&& !sup_setup_en && !sup_manual_en && !sup_adjust_en
		&& lower_tag != TAG_PAGE) ##1 $stable(lower_tag)
		|-> $stable(upper_value))
		else $error("value moved under lock");
	idle_bound_a: assert property (idle < IDLE_CYC + 64)
		else $error("idle exit missed");
	flash_mode_a: assert property (upper_flash
		|-> program_mode || $past(program_mode))
		else $error("flash outside program mode");
	reset_main_a: assert property ($past(rst)
		|-> !program_mode && !lock_on)
		else $error("not main and unlocked after reset");
	// Main scenarios reached
	cover property ($rose(lock_on));
	cover property (restart_req);
	cover property (upper_flash);
endmodule

bind fpm_menu fpm_menu_checker #(.IDLE_CYC(IDLE_CYC)) u_chk (
	.clk(clk), .rst(rst), .key_page_in(key_page_in),
	.key_up_in(key_up_in), .key_down_in(key_down_in),
	.key_enter_in(key_enter_in), .sup_setup_en(sup_setup_en),
	.sup_manual_en(sup_manual_en), .sup_adjust_en(sup_adjust_en),
	.restart_req(restart_req), .upper_value(upper_value),
	.lower_tag(lower_tag), .upper_flash(upper_flash),
	.program_mode(program_mode), .lock_on(lock_on)
);

/* verification/fpm_store.sv */
// Non-volatile store model behind the menu
`timescale 1ns/10ps
module fpm_store #(
	parameter int NPAR  = 4,
	parameter int IDX_W = 2
) (
	// Clock
	input  wire logic               clk,
	// Store port of the menu
	input  wire logic [IDX_W-1:0]   nv_addr,
	input  wire logic               nv_wr,
	input  wire logic signed [15:0] nv_wr_data,
	output logic signed [15:0]      nv_rd_data
);
	logic signed [15:0] mem [NPAR];
	// Contents have no reset, so they survive power loss
	initial mem = '{16'sh0001, 16'sh0000, 16'sh0004, 16'sh0003};
	// Store a committed value
	always @(posedge clk) if (nv_wr) mem[nv_addr] <= nv_wr_data;
	// Read the addressed entry at once
	assign nv_rd_data = mem[nv_addr];
endmodule

/* verification/tb.sv */
// Self-checking bench for the parameter menu
`timescale 1ns/10ps
module tb;
	import fpm_pkg::*;
	typedef struct packed {
		logic [1:0]  key;
		logic [15:0] up;
		logic [15:0] tag;
		logic        pm;
	} fpm_row_type;
	localparam int IDLE = 2000;
	logic               clk, rst, s_su, s_mn, s_ad, wr, rq, fl, pm, lk;
	logic [3:0]         keys, p_en, p_sp, p_vl;
	logic [1:0]         addr;
	logic signed [15:0] rd, wd;
	logic [15:0]        uv, lt;
	fpm_param_type      tbl [4];
	fpm_row_type        rows [17];
	int                 failures = 0, n_tests = 0, n_rq = 0, cyc = 0;
	fpm_menu #(.NPAR(4), .IDX_W(2), .IDLE_CYC(IDLE), .DEB_CYC(2),
		.RPT_DLY(20), .RPT_RATE(5)) u_dut (
		.clk(clk), .rst(rst), .key_page_in(keys[0]), .key_up_in(keys[1]),
		.key_down_in(keys[2]), .key_enter_in(keys[3]), .par_table(tbl),
		.par_enabled(p_en), .par_setpoint(p_sp), .par_valve(p_vl),
		.sup_setup_en(s_su), .sup_manual_en(s_mn), .sup_adjust_en(s_ad),
		.nv_rd_data(rd), .nv_addr(addr), .nv_wr(wr), .nv_wr_data(wd),
		.restart_req(rq), .upper_value(uv), .lower_tag(lt),
		.upper_flash(fl), .program_mode(pm), .lock_on(lk));
	fpm_store #(.NPAR(4), .IDX_W(2)) u_store (.clk(clk), .nv_addr(addr),
		.nv_wr(wr), .nv_wr_data(wd), .nv_rd_data(rd));
	// Clock at 125 MHz
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Restart pulses and hang guard
	always @(posedge clk) begin
		if (rq === 1'b1) n_rq <= n_rq + 1;
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			failures++;
			complete_run();
		end
	end
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Press and release one key, then let the answer settle
	task automatic tap(input int k, input int hold);
		@(posedge clk) keys[k] <= 1'b1;
		repeat (hold) @(posedge clk);
		keys[k] <= 1'b0;
		repeat (16) @(posedge clk);
		@(negedge clk);
	endtask
	// Select a page number and enter it
	task automatic open(input int n);
		tap(0, 6);
		repeat (n) tap(1, 6);
		tap(3, 6);
	endtask
	task automatic complete_run();
		$display("failures=%0d n_tests=%0d", failures, n_tests);
		if (failures == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		keys = 4'h0;
		rst = 1'b1;
		p_en = 4'hF;
		p_sp = 4'h1;
		p_vl = 4'h2;
		s_su = 1'b0;
		s_mn = 1'b0;
		s_ad = 1'b0;
		tbl[0] = '{8'h01, 16'h0101, 16'sh0000, 16'sh0005, 16'sh0002, 1'b0};
		tbl[1] = '{8'h01, 16'h0102, -16'sh0003, 16'sh0003, 16'sh0001, 1'b0};
		tbl[2] = '{8'h01, 16'h0103, 16'sh0000, 16'sh0009, 16'sh0005, 1'b1};
		tbl[3] = '{8'h00, 16'h0201, 16'sh0000, 16'sh0009, 16'sh0007, 1'b1};
		rows = '{
			'{2'h0, 16'h0000, TAG_PAGE, 1'b1},
			'{2'h1, 16'h0001, TAG_PAGE, 1'b1},
			'{2'h3, 16'h0001, 16'h0101, 1'b1},
			'{2'h1, 16'h0002, 16'h0101, 1'b1},
			'{2'h3, 16'h0000, 16'h0102, 1'b1},
			'{2'h2, 16'hFFFF, 16'h0102, 1'b1},
			'{2'h0, 16'h0000, TAG_MAIN, 1'b0},
			'{2'h0, 16'h0000, TAG_PAGE, 1'b1},
			'{2'h1, 16'h0001, TAG_PAGE, 1'b1},
			'{2'h3, 16'h0002, 16'h0101, 1'b1},
			'{2'h3, 16'h0000, 16'h0102, 1'b1},
			'{2'h3, 16'h0004, 16'h0103, 1'b1},
			'{2'h3, 16'h0002, 16'h0101, 1'b1},
			'{2'h1, 16'h0003, 16'h0101, 1'b1},
			'{2'h1, 16'h0004, 16'h0101, 1'b1},
			'{2'h1, 16'h0005, 16'h0101, 1'b1},
			'{2'h1, 16'h0005, 16'h0101, 1'b1}};
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		check(16'(lk), 16'h0000);
		check(lt, TAG_MAIN);
		foreach (rows[i]) begin
			tap(rows[i].key, 6);
			check(lt, rows[i].tag);
			check(16'(pm), 16'(rows[i].pm));
			if (rows[i].pm) check(uv, rows[i].up);
		end
		check(16'(fl), 16'h0001);
		tap(0, 6);
		check(u_store.mem[0], 16'h0002);
		tap(0, 6);
		tap(1, 45);
		check(16'(uv > 16'h0002), 16'h0001);
		tap(3, 6);
		check(16'(pm), 16'h0000);
		open(123);
		check(16'(lk), 16'h0001);
		check(16'(pm), 16'h0000);
		open(1);
		tap(1, 6);
		check(uv, 16'h0002);
		tap(0, 6);
		@(posedge clk) s_su <= 1'b1;
		open(1);
		tap(1, 6);
		check(uv, 16'h0003);
		tap(0, 6);
		@(posedge clk) {s_su, s_mn} <= 2'b01;
		open(1);
		tap(3, 6);
		tap(1, 6);
		check(uv, 16'h0001);
		tap(0, 6);
		@(posedge clk) {p_sp, p_vl} <= 8'h01;
		open(1);
		tap(1, 6);
		check(uv, 16'h0003);
		@(posedge clk) p_vl <= 4'h0;
		tap(1, 6);
		check(uv, 16'h0003);
		tap(0, 6);
		@(posedge clk) {s_mn, s_ad} <= 2'b01;
		open(0);
		tap(1, 6);
		check(uv, 16'h0004);
		tap(0, 6);
		@(posedge clk) s_ad <= 1'b0;
		open(99);
		check(16'(pm), 16'h0000);
		check(16'(n_rq), 16'h0000);
		open(123);
		check(16'(lk), 16'h0001);
		open(123);
		check(16'(lk), 16'h0000);
		open(99);
		for (int w = 0; w < 200 && n_rq == 0; w++) @(negedge clk);
		check(16'(n_rq), 16'h0001);
		foreach (tbl[i]) check(u_store.mem[i], tbl[i].def_val);
		@(posedge clk) p_en <= 4'hD;
		open(1);
		tap(3, 6);
		check(lt, 16'h0103);
		repeat (IDLE - 100) @(negedge clk);
		check(16'(pm), 16'h0001);
		repeat (200) @(negedge clk);
		check(16'(pm), 16'h0000);
		open(1);
		tap(1, 6);
		@(posedge clk) rst <= 1'b1;
		@(posedge clk) rst <= 1'b0;
		@(negedge clk);
		check(16'(pm), 16'h0000);
		check(u_store.mem[0], 16'h0002);
		complete_run();
	end
endmodule
